// File: qrw_consts.svh
`ifndef QRW_CONSTS_SVH
`define QRW_CONSTS_SVH

// ==========================================================================
// Instruction codes
`define QRW_OP_OCTAL_READ 8'hE3
`define QRW_OP_SET_WRAP 8'h77
`define QRW_OP_PAGE_PROG 8'h02

// ==========================================================================
// Field values and reset values
`define QRW_WRAP_RESET 3'h7
`define QRW_CONT_KEY 2'h2
`define QRW_WRAP_BASE 6'h08

// ==========================================================================
// Phase lengths in serial clocks, last count of each phase
`define QRW_CONT_ADDR_LAST 6'h05
`define QRW_OPCODE_LAST 6'h07
`define QRW_QADDR_LAST 6'h05
`define QRW_MODE_LAST 6'h01
`define QRW_DUMMY_LAST 6'h05
`define QRW_WBITS_LAST 6'h01
`define QRW_PADDR_LAST 6'h17
`define QRW_BIT_LAST 3'h7

// ==========================================================================
// Timing
`define QRW_CLK_PERIOD_NS 5
`define QRW_PROG_TIME_NS 400000

`endif

// File: qrw_pkg.sv
package qrw_pkg;

  typedef enum logic [8:0] {
    LK_CMD = 9'h001,
    LK_QADDR = 9'h002,
    LK_MODE = 9'h004,
    LK_DOUT = 9'h008,
    LK_WDUMMY = 9'h010,
    LK_WBITS = 9'h020,
    LK_PADDR = 9'h040,
    LK_PDATA = 9'h080,
    LK_IGNORE = 9'h100
  } qrw_link_t;

  typedef enum logic [2:0] {
    PG_IDLE = 3'h1,
    PG_WRITE = 3'h2,
    PG_WAIT = 3'h4
  } qrw_prog_t;

endpackage

// File: qrw_sequencer.sv
`timescale 1ns/1ps
`include "qrw_consts.svh"

// Behaviour
// - Enabled wrap confines reads to section
// - Wrapped output circles section until deselect
// - Octal read aligned address, no dummy clocks
// - Octal read accepted only with quad enable
// - Capture high four mode bits after address
// - Key 10 skips opcode next transaction
// - Other key returns to opcode decoding
// - Wrap config: opcode, 24 dummy, 8 bits
// - Wrap disable bit, length select 8..64
// - Wrap setting persists until reconfigured
// - Wrapping disabled after power on
// - Wrap length stays valid in four-lane mode
// - Page program needs write latch set
// - Program address wraps within page
// - Program only on byte-boundary deselect
// - Busy during self-timed program cycle
// - Completion clears write latch
// - Protected page refuses program
module qrw_sequencer #(
  parameter int PROG_CYCLES = (`QRW_PROG_TIME_NS + `QRW_CLK_PERIOD_NS - 1) / `QRW_CLK_PERIOD_NS,
  parameter int PAGE_BYTES = 256
)(
  input wire logic clk,
  input wire logic srst,
  input wire logic lk_sclk,
  input wire logic cs_n,
  input wire logic [3:0] io_in,
  output logic [3:0] io_out,
  output logic [3:0] io_oe,
  input wire logic quad_io_enable_bit,
  input wire logic write_enable_set,
  input wire logic protect_complement_bit,
  input wire logic protect_granularity_bit,
  input wire logic protect_top_bottom_bit,
  input wire logic protect_level_bit2,
  input wire logic protect_level_bit1,
  input wire logic protect_level_bit0,
  input wire logic [7:0] rd_byte,
  output logic [23:0] rd_addr,
  output logic busy,
  output logic write_latch_flag,
  output logic [2:0] wrap_control_bits,
  output logic cont_read_mode,
  output logic mem_wr_en,
  output logic [23:0] mem_wr_addr,
  output logic [7:0] mem_wr_data
);
  import qrw_pkg::*;

  localparam int IW = $clog2(PAGE_BYTES);
  localparam int TW = $clog2(PROG_CYCLES + 1);

  // ========================================================================
  // Link side: frame start, configuration seen on the serial clock
  logic frame_new_ff;
  qrw_link_t lk_state_ff;
  qrw_link_t st_now;
  logic [5:0] lk_cnt_ff;
  logic [5:0] cnt_now;
  logic [7:0] op_sh_ff;
  logic [23:0] addr_sh_ff;
  logic [23:0] rd_addr_ff;
  logic [3:0] mode_hi_ff;
  logic [3:0] wrap_hi_ff;
  logic [7:0] wrap_byte_ff;
  logic half_ff;
  logic [23:0] pp_addr_ff;
  logic [IW-1:0] pp_idx_ff;
  logic [6:0] dsh_ff;
  logic got_byte_ff;
  logic cont_next_ff;
  logic wrap_done_ff;
  logic [7:0] pg_buf [0:PAGE_BYTES-1];
  logic [PAGE_BYTES-1:0] loaded_ff;
  logic [6:0] cfg_s1_ff;
  logic [6:0] cfg_s2_ff;
  logic qe_q;
  logic wel_q;
  logic busy_q;
  logic cont_q;
  logic [2:0] wrap_q;
  logic [7:0] opcode;
  logic [5:0] wmask;
  logic [23:0] next_rd;
  logic armed;
  logic [3:0] io_out_ff;
  logic io_oe_ff;

  // Chip select high restarts the frame and clears the output enable; nothing else is forced, so the
  // levels the core samples at deselect hold until the next frame's first edge.
  always_ff @(posedge lk_sclk or posedge cs_n)
  begin
    if (cs_n)
      frame_new_ff <= 1'b1;
    else
      frame_new_ff <= 1'b0;
  end

  assign st_now = frame_new_ff ? LK_CMD : lk_state_ff;
  assign cnt_now = frame_new_ff ? 6'h00 : lk_cnt_ff;

  always_ff @(posedge lk_sclk)
  begin
    cfg_s1_ff <= {quad_io_enable_bit, write_latch_flag, busy, cont_read_mode, wrap_control_bits};
    cfg_s2_ff <= cfg_s1_ff;
  end

  assign {qe_q, wel_q, busy_q, cont_q, wrap_q} = cfg_s2_ff;
  assign opcode = {op_sh_ff[6:0], io_in[0]};

  // Section mask is length minus one, selected by the length field.
  assign wmask = (`QRW_WRAP_BASE << wrap_q[2:1]) - 6'h01;
  always_comb
  begin
    next_rd = rd_addr_ff + 24'h000001;
    if (!wrap_q[0])
      next_rd = {rd_addr_ff[23:6], (rd_addr_ff[5:0] & ~wmask) | (next_rd[5:0] & wmask)};
  end

  // ========================================================================
  // Link side: instruction phases
  always_ff @(posedge lk_sclk)
  begin
    lk_state_ff <= st_now;
    lk_cnt_ff <= cnt_now + 6'h01;
    op_sh_ff <= opcode;
    case (st_now)
      LK_CMD:
      begin
        addr_sh_ff <= {addr_sh_ff[19:0], io_in};
        if (cont_q && qe_q && !busy_q && cnt_now == `QRW_CONT_ADDR_LAST)
        begin
          rd_addr_ff <= {addr_sh_ff[19:0], io_in};
          lk_state_ff <= LK_MODE;
          lk_cnt_ff <= 6'h00;
        end
        else if (cnt_now == `QRW_OPCODE_LAST)
        begin
          lk_cnt_ff <= 6'h00;
          if (busy_q)
            lk_state_ff <= LK_IGNORE;
          else if (opcode == `QRW_OP_OCTAL_READ && qe_q)
            lk_state_ff <= LK_QADDR;
          else if (opcode == `QRW_OP_SET_WRAP)
            lk_state_ff <= LK_WDUMMY;
          else if (opcode == `QRW_OP_PAGE_PROG && wel_q)
            lk_state_ff <= LK_PADDR;
          else
            lk_state_ff <= LK_IGNORE;
        end
      end
      LK_QADDR:
      begin
        addr_sh_ff <= {addr_sh_ff[19:0], io_in};
        if (cnt_now == `QRW_QADDR_LAST)
        begin
          rd_addr_ff <= {addr_sh_ff[19:0], io_in};
          lk_state_ff <= LK_MODE;
          lk_cnt_ff <= 6'h00;
        end
      end
      LK_MODE:
      begin
        if (cnt_now == 6'h00)
          mode_hi_ff <= io_in;
        if (cnt_now == `QRW_MODE_LAST)
        begin
          // The low nibble of the mode byte is ignored; data follows at once.
          lk_state_ff <= LK_DOUT;
          half_ff <= 1'b0;
        end
      end
      LK_DOUT:
      begin
        half_ff <= ~half_ff;
        if (half_ff)
          rd_addr_ff <= next_rd;
      end
      LK_WDUMMY:
      begin
        if (cnt_now == `QRW_DUMMY_LAST)
        begin
          lk_state_ff <= LK_WBITS;
          lk_cnt_ff <= 6'h00;
        end
      end
      LK_WBITS:
      begin
        if (cnt_now == 6'h00)
          wrap_hi_ff <= io_in;
        if (cnt_now == `QRW_WBITS_LAST)
        begin
          wrap_byte_ff <= {wrap_hi_ff, io_in};
          lk_state_ff <= LK_IGNORE;
        end
      end
      LK_PADDR:
      begin
        addr_sh_ff <= {addr_sh_ff[22:0], io_in[0]};
        if (cnt_now == `QRW_PADDR_LAST)
        begin
          pp_addr_ff <= {addr_sh_ff[22:0], io_in[0]};
          pp_idx_ff <= addr_sh_ff[IW-2:0] == '0 ? {addr_sh_ff[IW-2:0], io_in[0]}
                                               : {addr_sh_ff[IW-2:0], io_in[0]};
          lk_state_ff <= LK_PDATA;
          lk_cnt_ff <= 6'h00;
        end
      end
      LK_PDATA:
      begin
        dsh_ff <= {dsh_ff[5:0], io_in[0]};
        if (cnt_now[2:0] == `QRW_BIT_LAST)
        begin
          pg_buf[pp_idx_ff] <= {dsh_ff, io_in[0]};
          pp_idx_ff <= pp_idx_ff + 1'b1;
        end
      end
      LK_IGNORE:
      begin
        lk_state_ff <= LK_IGNORE;
      end
      default:
      begin
        lk_state_ff <= LK_IGNORE;
      end
    endcase
  end

  // Per-frame outcome levels, cleared at the first edge of every frame.
  always_ff @(posedge lk_sclk)
  begin
    if (frame_new_ff)
    begin
      cont_next_ff <= 1'b0;
      wrap_done_ff <= 1'b0;
      got_byte_ff <= 1'b0;
      loaded_ff <= '0;
    end
    else
    begin
      if (st_now == LK_MODE && cnt_now == `QRW_MODE_LAST)
        cont_next_ff <= mode_hi_ff[1:0] == `QRW_CONT_KEY;
      if (st_now == LK_WBITS && cnt_now == `QRW_WBITS_LAST)
        wrap_done_ff <= 1'b1;
      if (st_now == LK_PDATA && cnt_now[2:0] == `QRW_BIT_LAST)
      begin
        got_byte_ff <= 1'b1;
        loaded_ff[pp_idx_ff] <= 1'b1;
      end
    end
  end

  // Armed only between whole bytes; a partial byte at deselect discards all.
  assign armed = (lk_state_ff == LK_PDATA) && (lk_cnt_ff[2:0] == 3'h0) && got_byte_ff;

  // Data leaves on the falling edge so the host samples it on the rising one.
  always_ff @(negedge lk_sclk)
  begin
    io_out_ff <= half_ff ? rd_byte[3:0] : rd_byte[7:4];
  end

  // Deselect drops the enable at once, so a new frame never opens with the
  // lanes still driven from the last read while the host sends its address.
  always_ff @(negedge lk_sclk or posedge cs_n)
  begin
    if (cs_n)
      io_oe_ff <= 1'b0;
    else
      io_oe_ff <= lk_state_ff == LK_DOUT;
  end

  assign io_out = io_out_ff;
  assign io_oe = {4{io_oe_ff & ~cs_n}};
  assign rd_addr = rd_addr_ff;

  // ========================================================================
  // Core side: deselect detection and commit
  logic [2:0] cs_sync_ff;
  logic [2:0] ev_s1_ff;
  logic [2:0] ev_s2_ff;
  logic cs_rise;
  logic [2:0] wrap_ctrl_ff;
  logic cont_mode_ff;
  logic wel_ff;
  logic busy_ff;
  qrw_prog_t pg_state_ff;
  logic [IW-1:0] wr_idx_ff;
  logic [TW-1:0] timer_ff;
  logic mem_wr_en_ff;
  logic [23:0] mem_wr_addr_ff;
  logic [7:0] mem_wr_data_ff;
  logic prot;

  // Fixed 4 MiB map: 64 blocks of 64 KiB or 1024 sectors of 4 KiB.
  function automatic logic prot_hit(input logic [23:0] a, input logic cmp, input logic sec,
                                    input logic tb, input logic [2:0] bp);
    logic [9:0] unit;
    logic [9:0] n;
    logic [9:0] total;
    logic hit;
    begin
      unit = sec ? a[21:12] : {4'h0, a[21:16]};
      total = sec ? 10'h3FF : 10'h03F;
      n = (sec && bp > 3'h4) ? 10'h008 : (10'h001 << (bp - 3'h1));
      hit = tb ? (unit < n) : (unit > total - n);
      if (bp == 3'h0)
        hit = 1'b0;
      prot_hit = hit ^ cmp;
    end
  endfunction

  assign prot = prot_hit(pp_addr_ff, protect_complement_bit, protect_granularity_bit,
                         protect_top_bottom_bit,
                         {protect_level_bit2, protect_level_bit1, protect_level_bit0});

  // The link levels settled long before deselect, so sampling them after the
  // synchronised chip-select edge sees stable values.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      cs_sync_ff <= 3'h7;
      ev_s1_ff <= 3'h0;
      ev_s2_ff <= 3'h0;
    end
    else
    begin
      cs_sync_ff <= {cs_sync_ff[1:0], cs_n};
      ev_s1_ff <= {armed, wrap_done_ff, cont_next_ff};
      ev_s2_ff <= ev_s1_ff;
    end
  end

  assign cs_rise = cs_sync_ff[1] & ~cs_sync_ff[2];

  always_ff @(posedge clk)
  begin
    if (srst)
      wrap_ctrl_ff <= `QRW_WRAP_RESET;
    else if (cs_rise && ev_s2_ff[1])
      wrap_ctrl_ff <= wrap_byte_ff[6:4];
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      cont_mode_ff <= 1'b0;
    else if (cs_rise)
      cont_mode_ff <= ev_s2_ff[0];
  end

  // ========================================================================
  // Core side: self-timed program cycle
  always_ff @(posedge clk)
  begin
    if (srst)
      wel_ff <= 1'b0;
    else if (write_enable_set)
      wel_ff <= 1'b1;
    else if (pg_state_ff == PG_WAIT && timer_ff == TW'(PROG_CYCLES - 1))
      wel_ff <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      pg_state_ff <= PG_IDLE;
      busy_ff <= 1'b0;
      wr_idx_ff <= '0;
      timer_ff <= '0;
      mem_wr_en_ff <= 1'b0;
      mem_wr_addr_ff <= 24'h000000;
      mem_wr_data_ff <= 8'h00;
    end
    else
    begin
      mem_wr_en_ff <= 1'b0;
      case (pg_state_ff)
        PG_IDLE:
        begin
          if (cs_rise && ev_s2_ff[2] && !prot)
          begin
            pg_state_ff <= PG_WRITE;
            busy_ff <= 1'b1;
            wr_idx_ff <= '0;
          end
        end
        PG_WRITE:
        begin
          mem_wr_en_ff <= loaded_ff[wr_idx_ff];
          mem_wr_addr_ff <= {pp_addr_ff[23:IW], wr_idx_ff};
          mem_wr_data_ff <= pg_buf[wr_idx_ff];
          wr_idx_ff <= wr_idx_ff + 1'b1;
          if (wr_idx_ff == IW'(PAGE_BYTES - 1))
          begin
            pg_state_ff <= PG_WAIT;
            timer_ff <= '0;
          end
        end
        PG_WAIT:
        begin
          timer_ff <= timer_ff + 1'b1;
          if (timer_ff == TW'(PROG_CYCLES - 1))
          begin
            pg_state_ff <= PG_IDLE;
            busy_ff <= 1'b0;
          end
        end
        default:
        begin
          pg_state_ff <= PG_IDLE;
          busy_ff <= 1'b0;
        end
      endcase
    end
  end

  assign busy = busy_ff;
  assign write_latch_flag = wel_ff;
  // The same stored length serves the four-lane burst instruction elsewhere.
  assign wrap_control_bits = wrap_ctrl_ff;
  assign cont_read_mode = cont_mode_ff;
  assign mem_wr_en = mem_wr_en_ff;
  assign mem_wr_addr = mem_wr_addr_ff;
  assign mem_wr_data = mem_wr_data_ff;

endmodule

// File: qrw_sequencer_properties.sv
`timescale 1ns/1ps
module qrw_checker #(
  parameter int PROG_CYCLES = 20,
  parameter int PAGE_BYTES = 256
)(
  input wire logic clk,
  input wire logic srst,
  input wire logic cs_n,
  input wire logic [3:0] io_oe,
  input wire logic quad_io_enable_bit,
  input wire logic write_enable_set,
  input wire logic busy,
  input wire logic write_latch_flag,
  input wire logic [2:0] wrap_control_bits,
  input wire logic cont_read_mode,
  input wire logic mem_wr_en,
  input wire logic [23:0] mem_wr_addr
);
  // ==========================================================================
  // Helper state
  logic [31:0] busy_len_ff;
  logic seen_ff;
  logic [15:0] page_ff;
  always_ff @(posedge clk)
  begin
    if (srst || !busy)
      busy_len_ff <= 32'h0;
    else
      busy_len_ff <= busy_len_ff + 32'h1;
  end
  // The page is learned from every write and checked on the next, so one program never mixes pages.
  always_ff @(posedge clk)
  begin
    if (srst || !busy)
      seen_ff <= 1'b0;
    else if (mem_wr_en)
      seen_ff <= 1'b1;
  end
  always_ff @(posedge clk)
  begin
    if (mem_wr_en)
      page_ff <= mem_wr_addr[23:8];
  end
  // ==========================================================================
  // Properties
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  sequence s_prog_start;
    $rose(busy);
  endsequence
  sequence s_prog_end;
    $fell(busy) ##0 !$past(write_enable_set);
  endsequence
  a_reset_wrap_off: assert property ($fell(srst) |-> wrap_control_bits == 3'h7
    && !busy && !write_latch_flag && !cont_read_mode) else $error("bad state after reset");
  a_prog_needs_latch: assert property (s_prog_start |-> write_latch_flag)
    else $error("program started without write latch");
  a_done_clears_latch: assert property (s_prog_end |-> !write_latch_flag)
    else $error("write latch kept after program");
  a_busy_full_time: assert property ($fell(busy) |->
    busy_len_ff >= PAGE_BYTES + PROG_CYCLES - 1) else $error("program cycle too short");
  a_write_while_busy: assert property (mem_wr_en |-> busy)
    else $error("array write outside program cycle");
  a_write_in_page: assert property (mem_wr_en && seen_ff |-> mem_wr_addr[23:8] == page_ff)
    else $error("program left its page");
  a_wrap_on_deselect: assert property ($changed(wrap_control_bits) |-> cs_n && $past(cs_n))
    else $error("wrap setting changed inside a frame");
  a_mode_on_deselect: assert property ($changed(cont_read_mode) |-> cs_n)
    else $error("continuous mode changed inside a frame");
  a_drive_when_sel: assert property (cs_n |-> io_oe == 4'h0)
    else $error("lanes driven while deselected");
  a_read_needs_qe: assert property (io_oe != 4'h0 |-> quad_io_enable_bit)
    else $error("lanes driven without quad enable");
endmodule
bind qrw_sequencer qrw_checker #(.PROG_CYCLES(PROG_CYCLES), .PAGE_BYTES(PAGE_BYTES)) u_chk (
  .clk(clk), .srst(srst), .cs_n(cs_n), .io_oe(io_oe),
  .quad_io_enable_bit(quad_io_enable_bit), .write_enable_set(write_enable_set),
  .busy(busy), .write_latch_flag(write_latch_flag), .wrap_control_bits(wrap_control_bits),
  .cont_read_mode(cont_read_mode), .mem_wr_en(mem_wr_en), .mem_wr_addr(mem_wr_addr));

// File: qrw_host_model.sv
`timescale 1ns/1ps
module qrw_host_model (
  output logic lk_sclk,
  output logic cs_n,
  output logic [3:0] io_in,
  input wire logic [3:0] io_out,
  input wire logic [3:0] io_oe
);
  logic [3:0] drv_val;
  logic drv_en;
  logic [3:0] float_val;
  // ==========================================================================
  // Lane level; undriven lanes toggle so a stale value never passes as data.
  assign io_in = (io_oe & io_out) | (~io_oe & (drv_en ? drv_val : float_val));
  initial
  begin
    lk_sclk = 1'b0;
    drv_en = 1'b0;
    drv_val = 4'h0;
    float_val = 4'h5;
    // Raised after time zero so the device sees a real deselect edge.
    #1;
    cs_n = 1'b1;
  end
  always #40 float_val = ~float_val;
  // ==========================================================================
  // Link cycles; the clock only runs inside frames.
  task automatic cyc(input logic [3:0] v, output logic [3:0] s, input logic rel = 1'b0);
    drv_val = v;
    #40;
    s = io_in;
    lk_sclk = 1'b1;
    #20;
    if (rel)
      drv_en = 1'b0;
    #20;
    lk_sclk = 1'b0;
  endtask
  task automatic sel();
    #17;
    cs_n = 1'b0;
    drv_en = 1'b1;
    #40;
  endtask
  task automatic unsel();
    #20;
    cs_n = 1'b1;
    drv_en = 1'b0;
    #300;
  endtask
  task automatic byte1(input logic [7:0] b);
    logic [3:0] s;
    for (int i = 7; i >= 0; i--)
      cyc({3'h0, b[i]}, s);
  endtask
  task automatic nibs(input logic [31:0] v, input int n, input logic rel);
    logic [3:0] s;
    for (int i = n - 1; i >= 0; i--)
      cyc(v[4*i +: 4], s, rel && i == 0);
  endtask
  task automatic rd(output logic [7:0] b);
    logic [3:0] s;
    cyc(4'h0, s);
    b[7:4] = s;
    cyc(4'h0, s);
    b[3:0] = s;
  endtask
  task automatic set_wrap(input logic [7:0] w);
    sel();
    byte1(8'h77);
    nibs({24'h0, w}, 8, 1'b0);
    unsel();
  endtask
endmodule

// File: quad_read_wrap_page_program_tb_top.sv
`timescale 1ns/1ps
module quad_read_wrap_page_program_tb_top;
  localparam int PROG_CYC = 20;
  localparam logic [10:0] ROWS [4] = '{{8'hEF, 3'h6}, {8'h2F, 3'h2}, {8'h5A, 3'h5},
    {8'h8F, 3'h0}};
  logic clk = 1'b0;
  logic srst, quad, wes;
  logic [5:0] prot;
  logic lk_sclk, cs_n;
  logic [3:0] io_in, io_out, io_oe;
  logic [7:0] rd_byte, mem_wr_data;
  logic [23:0] rd_addr, mem_wr_addr;
  logic busy, write_latch_flag, cont_read_mode, mem_wr_en;
  logic [2:0] wrap_control_bits;
  logic [7:0] wr_mem [256];
  logic [15:0] wr_page;
  int wr_cnt = 0;
  int error_cnt = 0;
  int tests_run = 0;
  always #2.5 clk = ~clk;
  assign rd_byte = rd_addr[7:0] ^ 8'h5A;
  qrw_sequencer #(.PROG_CYCLES(PROG_CYC)) u_qrw_sequencer (
    .clk(clk), .srst(srst), .lk_sclk(lk_sclk), .cs_n(cs_n), .io_in(io_in),
    .io_out(io_out), .io_oe(io_oe), .quad_io_enable_bit(quad), .write_enable_set(wes),
    .protect_complement_bit(prot[5]), .protect_granularity_bit(prot[4]),
    .protect_top_bottom_bit(prot[3]), .protect_level_bit2(prot[2]),
    .protect_level_bit1(prot[1]), .protect_level_bit0(prot[0]), .rd_byte(rd_byte),
    .rd_addr(rd_addr), .busy(busy), .write_latch_flag(write_latch_flag),
    .wrap_control_bits(wrap_control_bits), .cont_read_mode(cont_read_mode),
    .mem_wr_en(mem_wr_en), .mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data));
  qrw_host_model u_qrw_host_model (
    .lk_sclk(lk_sclk), .cs_n(cs_n), .io_in(io_in), .io_out(io_out), .io_oe(io_oe));
  always @(posedge clk)
  begin
    if (mem_wr_en === 1'b1)
    begin
      wr_mem[mem_wr_addr[7:0]] <= mem_wr_data;
      wr_page <= mem_wr_addr[23:8];
      wr_cnt <= wr_cnt + 1;
    end
  end
  // ==========================================================================
  // Tasks
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      $display("wrong value %s expected %0h seen %0h", name, exp, seen);
      error_cnt++;
    end
  endtask
  task automatic stop_test();
    if (error_cnt == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic wait_busy(input logic lvl, input int lim);
    for (int k = 0; k < lim && busy !== lvl; k++)
      @(posedge clk);
    check("busy", busy, lvl);
    if (busy !== lvl)
      stop_test();
  endtask
  // Reads wrap inside a section of wl bytes; refused reads leave every lane undriven.
  task automatic read_burst(input logic op, input logic [23:0] a, input logic [7:0] m,
    input int n, input int wl);
    logic [7:0] b;
    logic [7:0] wm;
    wm = 8'(wl - 1);
    u_qrw_host_model.sel();
    if (op)
      u_qrw_host_model.byte1(8'hE3);
    u_qrw_host_model.nibs({a, m}, 8, 1'b1);
    for (int i = 0; i < n; i++)
    begin
      u_qrw_host_model.rd(b);
      if (quad)
        check("rd_byte", b, ((a[7:0] & ~wm) | ((a[7:0] + 8'(i)) & wm)) ^ 8'h5A);
    end
    check("io_oe", io_oe, quad ? 4'hF : 4'h0);
    u_qrw_host_model.unsel();
  endtask
  task automatic prog(input int nb, input int extra);
    logic [3:0] s;
    u_qrw_host_model.sel();
    u_qrw_host_model.byte1(8'h02);
    u_qrw_host_model.byte1(8'h00);
    u_qrw_host_model.byte1(8'h01);
    u_qrw_host_model.byte1(8'hFE);
    for (int i = 0; i < nb; i++)
      u_qrw_host_model.byte1(8'(8'h11 * (i + 1)));
    for (int i = 0; i < extra; i++)
      u_qrw_host_model.cyc(4'h1, s);
    u_qrw_host_model.unsel();
    repeat (60) @(posedge clk);
  endtask
  // ==========================================================================
  // Sequence
  initial
  begin
    srst = 1'b1;
    quad = 1'b0;
    wes = 1'b0;
    prot = 6'h00;
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    repeat (4) @(posedge clk);
    check("wrap", wrap_control_bits, 3'h7);
    check("idle", {busy, write_latch_flag, cont_read_mode}, 3'h0);
    for (int r = 0; r < 4; r++)
    begin
      u_qrw_host_model.set_wrap(ROWS[r][10:3]);
      check("wrap", wrap_control_bits, ROWS[r][2:0]);
    end
    @(posedge clk);
    quad <= 1'b1;
    read_burst(1'b1, 24'h000130, 8'h20, 10, 8);
    check("cont", cont_read_mode, 1'b1);
    read_burst(1'b0, 24'h000240, 8'hF0, 2, 8);
    check("cont", cont_read_mode, 1'b0);
    read_burst(1'b1, 24'h000150, 8'h20, 1, 8);
    check("cont", cont_read_mode, 1'b1);
    u_qrw_host_model.sel();
    u_qrw_host_model.nibs(32'h11111111, 8, 1'b0);
    u_qrw_host_model.unsel();
    check("cont", cont_read_mode, 1'b0);
    @(posedge clk);
    quad <= 1'b0;
    read_burst(1'b1, 24'h000130, 8'h20, 1, 8);
    prog(3, 0);
    check("busy", busy, 1'b0);
    @(posedge clk);
    wes <= 1'b1;
    prot <= 6'h20;
    @(posedge clk);
    wes <= 1'b0;
    prog(3, 0);
    check("prot", {busy, write_latch_flag}, 2'h1);
    @(posedge clk);
    prot <= 6'h00;
    prog(2, 5);
    check("partial", {busy, write_latch_flag}, 2'h1);
    prog(3, 0);
    wait_busy(1'b1, 100);
    check("latch", write_latch_flag, 1'b1);
    wait_busy(1'b0, 2000);
    check("latch", write_latch_flag, 1'b0);
    check("page", wr_page, 16'h0001);
    check("mem", {wr_mem[8'hFE], wr_mem[8'hFF], wr_mem[8'h00]}, 24'h112233);
    check("count", wr_cnt, 3);
    // A mid-run reset while wrapping is enabled; the host then sets wrap off with an 8-byte length.
    @(posedge clk);
    srst <= 1'b1;
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    repeat (4) @(posedge clk);
    check("wrap", wrap_control_bits, 3'h7);
    u_qrw_host_model.set_wrap(8'h1F);
    check("wrap", wrap_control_bits, 3'h1);
    @(posedge clk);
    quad <= 1'b1;
    read_burst(1'b1, 24'h0001F0, 8'h00, 18, 256);
    stop_test();
  end
endmodule
